// File: ubs_top.sv
// Channel baud select, receiver control and interrupt negation behind AHB-Lite
`timescale 1ns/1ps
module ubs_top (
    input  wire logic        CLK_SYS,
    input  wire logic        RESET_N,
    input  wire logic        HSEL,
    input  wire logic [7:0]  HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic [31:0] HWDATA,
    input  wire logic        HREADY,
    output logic      [31:0] HRDATA,
    output logic             HREADYOUT,
    output logic             HRESP,
    input  wire logic        RXD,
    output logic             TXD,
    input  wire logic        AUX_IO_TWO,
    input  wire logic        MP_INPUT,
    output logic             INTR_OUT,
    output logic             MP_RECEIVER_READY_FLAG_N,
    output logic             MP_TRANSMITTER_READY_FLAG_N,
    output logic      [3:0]  TEST_PORT
);
    localparam int NEG_MAX = ubs_pkg::INT_NEG_CYC;

    logic [2:0]  rxd_s_q, aux_s_q, mpi_s_q;
    logic        rxd_f_q, aux_f_q, mpi_f_q;
    logic        wr_q, hreadyout_q, hresp_q;
    logic [5:0]  widx_q;
    logic [31:0] hrdata_q;
    logic [7:0]  mode1_q, clksel_q, imr_q, thr_q, rhr_q, rx_sh_q;
    logic        aux7_q, brg_test_q, test1x_q, rx_en_q, tx_en_q;
    logic [15:0] ctpre_q, ct_cnt_q;
    logic        ct_run_q, ct_tick_q;
    logic [2:0]  sticky_q;
    logic        irq_q, mp_rx_n_q, mp_tx_n_q;
    logic [3:0]  tport_q;
    logic        rx_busy_q, brk_q, rhr_full_q;
    logic [3:0]  rx_ph_q, rx_bit_q;
    logic        thr_full_q, txd_q;
    logic [8:0]  tx_sh_q;
    logic [3:0]  tx_left_q, tx_ph_q;
    logic        rx_gen_tick, tx_gen_tick;

    // Pin edges count once the second and third stages agree
    wire aux_ok   = aux_s_q[1] == aux_s_q[2];
    wire aux_rise = aux_ok & aux_s_q[2] & ~aux_f_q;
    wire aux_fall = aux_ok & ~aux_s_q[2] & aux_f_q;
    wire mpi_chg  = (mpi_s_q[1] == mpi_s_q[2]) & (mpi_s_q[2] != mpi_f_q);

    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            rxd_s_q <= 3'h7;
            aux_s_q <= 3'h0;
            mpi_s_q <= 3'h0;
            rxd_f_q <= 1'b1;
            aux_f_q <= 1'b0;
            mpi_f_q <= 1'b0;
        end else begin
            rxd_s_q <= {rxd_s_q[1:0], RXD};
            aux_s_q <= {aux_s_q[1:0], AUX_IO_TWO};
            mpi_s_q <= {mpi_s_q[1:0], MP_INPUT};
            if (rxd_s_q[1] == rxd_s_q[2]) rxd_f_q <= rxd_s_q[2];
            if (aux_ok) aux_f_q <= aux_s_q[2];
            if (mpi_s_q[1] == mpi_s_q[2]) mpi_f_q <= mpi_s_q[2];
        end
    end

    // Bus decode; zero wait states, reads latched at the address phase
    wire       a_go    = HSEL & HREADY & HTRANS[1];
    wire       rd_go   = a_go & ~HWRITE;
    wire [5:0] rd_idx  = HADDR[7:2];
    wire       rd_stat = rd_go & (rd_idx == ubs_pkg::IDX_STATUS);
    wire       rd_t1x  = rd_go & (rd_idx == ubs_pkg::IDX_TEST1X);
    wire       rd_hold = rd_go & (rd_idx == ubs_pkg::IDX_HOLD);
    wire       w_mode  = wr_q & (widx_q == ubs_pkg::IDX_MODE1);
    wire       w_csel  = wr_q & (widx_q == ubs_pkg::IDX_CLKSEL);
    wire       w_cmd   = wr_q & (widx_q == ubs_pkg::IDX_CMD);
    wire       w_aux   = wr_q & (widx_q == ubs_pkg::IDX_AUXCTL);
    wire       w_isr   = wr_q & (widx_q == ubs_pkg::IDX_ISR);
    wire       w_imr   = wr_q & (widx_q == ubs_pkg::IDX_IMR);
    wire       w_hold  = wr_q & (widx_q == ubs_pkg::IDX_HOLD);
    wire       w_ctpre = wr_q & (widx_q == ubs_pkg::IDX_CTPRE);

    // Commands
    wire [3:0] cmd_op      = HWDATA[7:4];
    wire       cmd_rx_en   = w_cmd & (HWDATA[1:0] == ubs_pkg::FLD_ENA);
    wire       cmd_rx_dis  = w_cmd & (HWDATA[1:0] == ubs_pkg::FLD_DIS);
    wire       cmd_tx_en   = w_cmd & (HWDATA[3:2] == ubs_pkg::FLD_ENA);
    wire       cmd_tx_dis  = w_cmd & (HWDATA[3:2] == ubs_pkg::FLD_DIS);
    wire       cmd_rx_rst  = w_cmd & (cmd_op == ubs_pkg::CMD_RX_RESET);
    wire       cmd_tx_rst  = w_cmd & (cmd_op == ubs_pkg::CMD_TX_RESET);
    wire       cmd_brk_rst = w_cmd & (cmd_op == ubs_pkg::CMD_BRK_RST);
    wire       cmd_inp_rst = w_cmd & (cmd_op == ubs_pkg::CMD_INP_RST);
    wire       cmd_ct_go   = w_cmd & (cmd_op == ubs_pkg::CMD_CT_START);
    wire       cmd_ct_stop = w_cmd & (cmd_op == ubs_pkg::CMD_CT_STOP);

    // Wake-up field at 11 keeps the receiver listening; host must leave it first
    wire wake    = mode1_q[ubs_pkg::WAKE_HI:ubs_pkg::WAKE_LO] == ubs_pkg::WAKE_ON;
    wire rx_kill = (cmd_rx_rst | cmd_rx_dis) & ~wake;
    wire rx_live = rx_en_q | wake;

    // Clock selection per direction
    wire [3:0]  rx_code = clksel_q[7:4];
    wire [3:0]  tx_code = clksel_q[3:0];
    wire [15:0] rx_div  = ubs_pkg::rate_div(rx_code, aux7_q, brg_test_q);
    wire [15:0] tx_div  = ubs_pkg::rate_div(tx_code, aux7_q, brg_test_q);
    wire        rx_1x   = test1x_q | (rx_code == ubs_pkg::CS_EXT1);
    wire        tx_1x   = test1x_q | (tx_code == ubs_pkg::CS_EXT1);
    wire        rx_tick = (rx_code == ubs_pkg::CS_EXT16 || rx_code == ubs_pkg::CS_EXT1) ? aux_rise :
                          (rx_code == ubs_pkg::CS_TIMER) ? ct_tick_q : rx_gen_tick;
    wire        tx_tick = (tx_code == ubs_pkg::CS_EXT16) ? aux_rise :
                          (tx_code == ubs_pkg::CS_EXT1) ? aux_fall :
                          (tx_code == ubs_pkg::CS_TIMER) ? ct_tick_q : tx_gen_tick;

    ubs_tick_gen #(.W(16)) u_rx_gen (
        .clk    (CLK_SYS),
        .rst_n  (RESET_N),
        .div    (rx_div),
        .tick_q (rx_gen_tick)
    );

    ubs_tick_gen #(.W(16)) u_tx_gen (
        .clk    (CLK_SYS),
        .rst_n  (RESET_N),
        .div    (tx_div),
        .tick_q (tx_gen_tick)
    );

    // Receiver
    wire rx_start = rx_live & ~rx_busy_q & rx_tick & ~rxd_f_q;
    wire rx_smp   = rx_busy_q & rx_tick & (rx_1x | (rx_ph_q == ubs_pkg::RX_MID));
    wire rx_last  = rx_smp & (rx_bit_q == ubs_pkg::RX_STOP);
    wire rx_brk   = rx_last & ~rxd_f_q & (rx_sh_q == 8'h00);
    wire rx_done  = rx_last & ~rx_brk;
    wire brk_d    = rx_brk | (brk_q & ~(rxd_f_q & ~rx_busy_q));
    wire brk_chg  = brk_d ^ brk_q;

    // Reset only stops the engine; mode, clock select and held data stay
    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            rx_busy_q <= 1'b0;
            rx_ph_q   <= 4'h0;
            rx_bit_q  <= 4'h0;
            rx_sh_q   <= 8'h00;
        end else if (rx_kill) begin
            rx_busy_q <= 1'b0;
        end else if (rx_start) begin
            rx_busy_q <= 1'b1;
            rx_ph_q   <= 4'h0;
            rx_bit_q  <= rx_1x ? 4'h1 : 4'h0;
        end else if (rx_busy_q) begin
            if (rx_tick) rx_ph_q <= rx_ph_q + 4'h1;
            if (rx_last || (rx_smp && rx_bit_q == 4'h0 && rxd_f_q)) begin
                rx_busy_q <= 1'b0;
            end else if (rx_smp) begin
                rx_bit_q <= rx_bit_q + 4'h1;
                if (rx_bit_q != 4'h0) rx_sh_q <= {rxd_f_q, rx_sh_q[7:1]};
            end
        end
    end

    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            brk_q      <= 1'b0;
            rhr_q      <= 8'h00;
            rhr_full_q <= 1'b0;
        end else begin
            brk_q      <= brk_d;
            rhr_full_q <= rx_done | (rhr_full_q & ~rd_hold);
            if (rx_done) rhr_q <= rx_sh_q;
        end
    end

    // Transmitter
    wire tx_step = tx_tick & (tx_1x | (tx_ph_q == 4'hf));
    wire tx_load = tx_step & (tx_left_q == 4'h0) & thr_full_q & tx_en_q;
    wire transmitter_ready_flag   = ~thr_full_q & tx_en_q;

    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            thr_full_q <= 1'b0;
            tx_sh_q    <= 9'h1ff;
            tx_left_q  <= 4'h0;
            tx_ph_q    <= 4'h0;
            txd_q      <= 1'b1;
        end else begin
            thr_full_q <= ~cmd_tx_rst & (w_hold | (thr_full_q & ~tx_load));
            if (tx_tick) tx_ph_q <= tx_ph_q + 4'h1;
            if (cmd_tx_rst) begin
                tx_left_q <= 4'h0;
                txd_q     <= 1'b1;
            end else if (tx_load) begin
                tx_sh_q   <= {1'b1, thr_q};
                tx_left_q <= ubs_pkg::TX_BITS;
                txd_q     <= 1'b0;
            end else if (tx_step && tx_left_q != 4'h0) begin
                txd_q     <= tx_sh_q[0];
                tx_sh_q   <= {1'b1, tx_sh_q[8:1]};
                tx_left_q <= tx_left_q - 4'h1;
            end
        end
    end

    // Counter/timer; its expiry is the 16x tick for code 1101
    wire ct_set = ct_run_q & (ct_cnt_q == 16'h0000);

    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            ct_run_q  <= 1'b0;
            ct_cnt_q  <= 16'h0000;
            ct_tick_q <= 1'b0;
        end else begin
            ct_tick_q <= ct_set;
            if (cmd_ct_go) begin
                ct_run_q <= 1'b1;
                ct_cnt_q <= ctpre_q;
            end else if (cmd_ct_stop) begin
                ct_run_q <= 1'b0;
            end else if (ct_set) begin
                ct_cnt_q <= ctpre_q;
            end else if (ct_run_q) begin
                ct_cnt_q <= ct_cnt_q - 16'h0001;
            end
        end
    end

    // Interrupts: two live levels and three sticky events; set beats clear
    wire [2:0] stk_set = {ct_set, mpi_chg, brk_chg};
    wire [2:0] stk_clr = ({3{w_isr}} & HWDATA[ubs_pkg::ISR_STK_HI:ubs_pkg::ISR_STK_LO])
                       | {cmd_ct_stop, cmd_inp_rst, cmd_brk_rst};
    wire [4:0] isr_w   = {sticky_q, rhr_full_q, transmitter_ready_flag};

    // Control registers and test modes
    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            mode1_q    <= ubs_pkg::MODE1_RST;
            clksel_q   <= ubs_pkg::CLKSEL_RST;
            ctpre_q    <= ubs_pkg::CTPRE_RST;
            aux7_q     <= 1'b0;
            imr_q      <= 8'h00;
            thr_q      <= 8'h00;
            rx_en_q    <= 1'b0;
            tx_en_q    <= 1'b0;
            brg_test_q <= 1'b0;
            test1x_q   <= 1'b0;
            sticky_q   <= 3'h0;
        end else begin
            if (w_mode) mode1_q <= HWDATA[7:0];
            if (w_csel) clksel_q <= HWDATA[7:0];
            if (w_ctpre) ctpre_q <= HWDATA[15:0];
            if (w_aux) aux7_q <= HWDATA[ubs_pkg::ACR_SET];
            if (w_imr) imr_q <= HWDATA[7:0];
            if (w_hold) thr_q <= HWDATA[7:0];
            if (rx_kill) rx_en_q <= 1'b0;
            else if (cmd_rx_en) rx_en_q <= 1'b1;
            if (cmd_tx_rst || cmd_tx_dis) tx_en_q <= 1'b0;
            else if (cmd_tx_en) tx_en_q <= 1'b1;
            if (rd_stat) brg_test_q <= ~brg_test_q;
            if (rd_t1x) test1x_q <= ~test1x_q;
            sticky_q <= (sticky_q & ~stk_clr) | stk_set;
        end
    end

    // Read data
    wire [31:0] rd_mux =
        (rd_idx == ubs_pkg::IDX_MODE1)  ? {24'h0, mode1_q} :
        (rd_idx == ubs_pkg::IDX_CLKSEL) ? {24'h0, clksel_q} :
        (rd_idx == ubs_pkg::IDX_STATUS) ? {25'h0, test1x_q, brg_test_q, brk_q, tx_left_q != 4'h0,
                                           ~thr_full_q, rhr_full_q, rx_live} :
        (rd_idx == ubs_pkg::IDX_AUXCTL) ? {24'h0, aux7_q, 7'h00} :
        (rd_idx == ubs_pkg::IDX_ISR)    ? {27'h0, isr_w} :
        (rd_idx == ubs_pkg::IDX_IMR)    ? {24'h0, imr_q} :
        (rd_idx == ubs_pkg::IDX_HOLD)   ? {24'h0, rhr_q} :
        (rd_idx == ubs_pkg::IDX_CTPRE)  ? {16'h0, ctpre_q} :
        (rd_idx == ubs_pkg::IDX_TEST1X) ? {30'h0, test1x_q, brg_test_q} : 32'h0;

    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            wr_q        <= 1'b0;
            widx_q      <= 6'h00;
            hrdata_q    <= 32'h0;
            hreadyout_q <= 1'b1;
            hresp_q     <= 1'b0;
        end else begin
            wr_q        <= a_go & HWRITE & (HSIZE == 3'h2);
            widx_q      <= rd_idx;
            hreadyout_q <= 1'b1;
            hresp_q     <= 1'b0;
            if (rd_go) hrdata_q <= rd_mux;
        end
    end

    // Registered pins; one edge after the cause keeps every negation under 270 ns
    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            irq_q     <= 1'b0;
            mp_rx_n_q <= 1'b1;
            mp_tx_n_q <= 1'b1;
            tport_q   <= 4'h0;
        end else begin
            irq_q     <= |(isr_w & imr_q[4:0]);
            mp_rx_n_q <= ~rhr_full_q;
            mp_tx_n_q <= ~transmitter_ready_flag;
            tport_q   <= test1x_q ? {rx_tick, tx_tick, rx_smp, tx_step} : 4'h0;
        end
    end

    assign HRDATA     = hrdata_q;
    assign HREADYOUT  = hreadyout_q;
    assign HRESP      = hresp_q;
    assign TXD        = txd_q;
    assign INTR_OUT   = irq_q;
    assign MP_RECEIVER_READY_FLAG_N = mp_rx_n_q;
    assign MP_TRANSMITTER_READY_FLAG_N = mp_tx_n_q;
    assign TEST_PORT  = tport_q;

    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RESET_N);

    sequence s_hold_read;
        rd_hold && !rx_done;
    endsequence
    sequence s_ready_gone;
        ##[1:NEG_MAX] MP_RECEIVER_READY_FLAG_N;
    endsequence

    a_code_zero_rate: assert property (!brg_test_q && rx_code == 4'h0 |->
        rx_div == (aux7_q ? ubs_pkg::bdiv(750) : ubs_pkg::bdiv(500))) else $error("code 0 rate wrong");
    a_timer_source: assert property (rx_code == ubs_pkg::CS_TIMER && ct_tick_q |-> rx_tick)
        else $error("timer does not clock receiver");
    a_test_toggle: assert property (rd_stat |=> brg_test_q != $past(brg_test_q))
        else $error("test mode did not toggle");
    a_test_rate_set: assert property (brg_test_q && tx_code == 4'h6 |-> tx_div == ubs_pkg::bdiv(1152000))
        else $error("test rate set not applied");
    a_test1x_port: assert property (test1x_q && rx_tick |=> TEST_PORT[3])
        else $error("internal node missing on port");
    a_rx_reset_keep: assert property (cmd_rx_rst |=> $stable(mode1_q) && $stable(clksel_q))
        else $error("receiver reset changed programming");
    a_wake_bypass: assert property (wake && rx_en_q && (cmd_rx_dis || cmd_rx_rst) |=> rx_en_q)
        else $error("wake-up receiver disabled");
    a_rhr_read_neg: assert property (s_hold_read |-> s_ready_gone)
        else $error("receive ready not negated");
    a_thr_write_neg: assert property (w_hold |-> ##[1:NEG_MAX] MP_TRANSMITTER_READY_FLAG_N)
        else $error("transmit ready not negated");
    a_brk_reset_neg: assert property (cmd_brk_rst && !brk_chg |=>
        !sticky_q[0] ##[0:NEG_MAX] !INTR_OUT || imr_q[4:0] != 5'h04) else $error("break change not negated");
    a_ct_stop_neg: assert property (cmd_ct_stop && !ct_set |=> !sticky_q[2] && !ct_run_q)
        else $error("counter interrupt not negated");
    a_mask_clear_neg: assert property (w_imr && HWDATA[4:0] == 5'h00 |-> ##[1:NEG_MAX] !INTR_OUT)
        else $error("mask clear did not negate");
    a_tx_falling: assert property (tx_code == ubs_pkg::CS_EXT1 && $stable(clksel_q) && $changed(TXD)
        && !$past(cmd_tx_rst) |-> $past(aux_fall)) else $error("transmit changed off falling edge");
    a_rx_rising: assert property (rx_code == ubs_pkg::CS_EXT1 && rx_smp |-> aux_rise)
        else $error("receive sampled off rising edge");
endmodule

// File: ubs_tick_gen.sv
// Shared constants, rate table and the baud tick divider
`timescale 1ns/1ps
package ubs_pkg;
    localparam int CLK_HZ        = 10_000_000;
    localparam int CLK_PERIOD_NS = 100;
    localparam int T_INT_NEG_NS  = 270;
    localparam int INT_NEG_CYC   = (T_INT_NEG_NS / CLK_PERIOD_NS) < 1 ? 1 : T_INT_NEG_NS / CLK_PERIOD_NS;
    localparam int OVERSAMPLE    = 16;

    localparam logic [5:0] IDX_MODE1  = 6'h00;
    localparam logic [5:0] IDX_CLKSEL = 6'h01;
    localparam logic [5:0] IDX_STATUS = 6'h02;
    localparam logic [5:0] IDX_CMD    = 6'h03;
    localparam logic [5:0] IDX_AUXCTL = 6'h04;
    localparam logic [5:0] IDX_ISR    = 6'h05;
    localparam logic [5:0] IDX_IMR    = 6'h06;
    localparam logic [5:0] IDX_HOLD   = 6'h07;
    localparam logic [5:0] IDX_CTPRE  = 6'h08;
    localparam logic [5:0] IDX_TEST1X = 6'h0a;

    localparam int         WAKE_LO    = 3;
    localparam int         WAKE_HI    = 4;
    localparam logic [1:0] WAKE_ON    = 2'h3;
    localparam int         ACR_SET    = 7;
    localparam int         ISR_STK_LO = 2;
    localparam int         ISR_STK_HI = 4;
    localparam logic [1:0] FLD_ENA    = 2'h1;
    localparam logic [1:0] FLD_DIS    = 2'h2;

    localparam logic [3:0] CS_TIMER   = 4'hd;
    localparam logic [3:0] CS_EXT16   = 4'he;
    localparam logic [3:0] CS_EXT1    = 4'hf;

    localparam logic [7:0]  MODE1_RST  = 8'h00;
    localparam logic [7:0]  CLKSEL_RST = 8'hbb;
    localparam logic [15:0] CTPRE_RST  = 16'h0010;
    localparam logic [3:0]  RX_STOP    = 4'h9;
    localparam logic [3:0]  RX_MID     = 4'h7;
    localparam logic [3:0]  TX_BITS    = 4'h9;

    typedef enum logic [3:0] {
        CMD_NONE     = 4'b0000,
        CMD_RX_RESET = 4'b0001,
        CMD_TX_RESET = 4'b0010,
        CMD_BRK_RST  = 4'b0101,
        CMD_INP_RST  = 4'b0110,
        CMD_CT_START = 4'b0111,
        CMD_CT_STOP  = 4'b1000
    } ubs_cmd_t;

    // Divider for a 16x tick at a rate given in tenths of a baud
    function automatic logic [15:0] bdiv(input int r10);
        return 16'((CLK_HZ * 10 + 8 * r10) / (OVERSAMPLE * r10));
    endfunction

    // Normal set, or test set when t is high; a is auxiliary control bit 7
    function automatic logic [15:0] rate_div(input logic [3:0] c, input logic a, input logic t);
        logic [15:0] d;
        d = bdiv(500);
        case (c)
            4'h0: d = t ? (a ? bdiv(72000) : bdiv(48000)) : (a ? bdiv(750) : bdiv(500));
            4'h1: d = t ? bdiv(8800) : bdiv(1100);
            4'h2: d = a ? bdiv(384000) : (t ? bdiv(10760) : bdiv(1345));
            4'h3: d = t ? (a ? bdiv(144000) : bdiv(192000)) : (a ? bdiv(1500) : bdiv(2000));
            4'h4: d = t ? bdiv(288000) : bdiv(3000);
            4'h5: d = t ? bdiv(576000) : bdiv(6000);
            4'h6: d = t ? bdiv(1152000) : bdiv(12000);
            4'h7: d = a ? bdiv(20000) : bdiv(10500);
            4'h8: d = t ? bdiv(576000) : bdiv(24000);
            4'h9: d = bdiv(48000);
            4'ha: d = t ? (a ? bdiv(144000) : bdiv(576000)) : (a ? bdiv(18000) : bdiv(72000));
            4'hb: d = bdiv(96000);
            4'hc: d = a ? bdiv(192000) : bdiv(384000);
            default: d = bdiv(500);
        endcase
        return d;
    endfunction
endpackage

module ubs_tick_gen #(parameter int W = 16) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] div,
    output logic              tick_q
);
    logic [W-1:0] cnt_q;

    // A new divider takes effect at the next wrap, so no runt tick
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q  <= '0;
            tick_q <= 1'b0;
        end else if (cnt_q == '0) begin
            cnt_q  <= div - W'(1);
            tick_q <= 1'b1;
        end else begin
            cnt_q  <= cnt_q - W'(1);
            tick_q <= 1'b0;
        end
    end
endmodule

// File: ubs_remote.sv
// Remote serial unit on the line side: 1X link clock, byte send and receive
`timescale 1ns/1ps
module ubs_remote (
    input  wire logic txd,
    output logic      rxd,
    output logic      aux_clk
);
    bit run;
    initial begin
        rxd = 1'b1;
        aux_clk = 1'b0;
        run = 1'b0;
    end
    // Link clock stands still between frames
    always #400 if (run) aux_clk = ~aux_clk;
    task automatic send_ext(input logic [7:0] b, input logic stp);
        logic [9:0] f;
        f = {stp, b, 1'b0};
        run = 1'b1;
        for (int i = 0; i < 10; i++) begin
            @(negedge aux_clk) rxd = f[i];
        end
        // Line back to idle, so an all-zero frame with a low stop bit ends as a break
        @(negedge aux_clk);
        rxd = 1'b1;
        run = 1'b0;
    endtask
    task automatic recv_ext(output logic [7:0] b);
        run = 1'b1;
        do @(posedge aux_clk); while (txd);
        for (int i = 0; i < 8; i++) begin
            @(posedge aux_clk) b[i] = txd;
        end
        @(posedge aux_clk) run = 1'b0;
    endtask
    task automatic recv_int(input int bit_ns, output logic [7:0] b);
        @(negedge txd) #(bit_ns / 2);
        for (int i = 0; i < 8; i++) begin
            #(bit_ns) b[i] = txd;
        end
    endtask
endmodule

// File: tb.sv
// Self-checking bench: rate selection, test modes, receiver reset, interrupt negation
`timescale 1ns/1ps
module tb;
    logic        clk_sys = 1'b0;
    logic        reset_n = 1'b0;
    logic        mp_input = 1'b0;
    logic [7:0]  haddr = 8'h00;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata, v;
    logic        hready, hresp, rxd, txd, aux, intr, rx_n, tx_n, lo;
    logic [3:0]  tport, tp;
    logic [7:0]  b;
    int          num_errors = 0;
    int          tests_run = 0;
    int          cyc = 0;
    always #50 clk_sys = ~clk_sys;
    ubs_top u_dut (.CLK_SYS(clk_sys), .RESET_N(reset_n), .HSEL(1'b1), .HADDR(haddr), .HTRANS(htrans),
        .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready),
        .HRESP(hresp), .RXD(rxd), .TXD(txd), .AUX_IO_TWO(aux), .MP_INPUT(mp_input), .INTR_OUT(intr),
        .MP_RECEIVER_READY_FLAG_N(rx_n), .MP_TRANSMITTER_READY_FLAG_N(tx_n), .TEST_PORT(tport));
    ubs_remote u_rem (.txd(txd), .rxd(rxd), .aux_clk(aux));
    task automatic report_and_stop;
        $display("Compares %0d, mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic xfer(input logic w, input logic [5:0] i, input logic [31:0] d);
        @(posedge clk_sys);
        htrans <= 2'h2;
        haddr <= {i, 2'h0};
        hwrite <= w;
        do @(posedge clk_sys); while (!hready);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk_sys); while (!hready);
        v = hrdata;
    endtask
    task automatic wr(input logic [5:0] i, input logic [31:0] d);
        xfer(1'b1, i, d);
    endtask
    task automatic rdc(input logic [5:0] i, input logic [31:0] m, input logic [31:0] e);
        xfer(1'b0, i, 32'h0);
        chk(v & m, e);
    endtask
    // Status reads toggle the rate test mode, so they go in pairs
    task automatic sts(input logic [31:0] m, input logic [31:0] e);
        rdc(6'h02, m, e);
        xfer(1'b0, 6'h02, 32'h0);
    endtask
    task automatic wait_int;
        repeat (400) if (intr !== 1'b1) @(posedge clk_sys);
        chk(32'(intr), 32'h1);
    endtask
    task automatic nego;
        lo = 1'b0;
        repeat (3) begin
            @(posedge clk_sys);
            if (intr === 1'b0) lo = 1'b1;
        end
        chk(32'(lo), 32'h1);
    endtask
    function automatic int bit_ns(input int baud);
        return 16 * ((ubs_pkg::CLK_HZ + 8 * baud) / (16 * baud)) * ubs_pkg::CLK_PERIOD_NS;
    endfunction
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 40000) begin
            num_errors++;
            report_and_stop;
        end
    end
    initial begin
        repeat (10) @(posedge clk_sys);
        reset_n <= 1'b1;
        rdc(6'h02, 32'h60, 32'h00);
        rdc(6'h02, 32'h20, 32'h20);
        rdc(6'h0a, 32'h03, 32'h00);
        tp = 4'h0;
        repeat (100) begin
            @(posedge clk_sys);
            tp = tp | tport;
        end
        chk(32'(tp != 4'h0), 32'h1);
        rdc(6'h0a, 32'h03, 32'h02);
        rdc(6'h01, 32'hff, 32'hbb);
        rdc(6'h09, 32'hffffffff, 32'h0);
        chk(32'(hresp), 32'h0);
        wr(6'h04, 32'h80);
        wr(6'h01, 32'hcc);
        wr(6'h03, 32'h04);
        fork
            u_rem.recv_int(bit_ns(19200), b);
            wr(6'h07, 32'ha5);
        join
        chk(32'(b), 32'ha5);
        repeat (700) @(posedge clk_sys);
        rdc(6'h02, 32'h20, 32'h00);
        wr(6'h01, 32'h66);
        fork
            u_rem.recv_int(bit_ns(115200), b);
            wr(6'h07, 32'h3c);
        join
        chk(32'(b), 32'h3c);
        repeat (200) @(posedge clk_sys);
        wr(6'h06, 32'h01);
        wait_int;
        wr(6'h06, 32'h00);
        nego;
        wr(6'h06, 32'h01);
        wait_int;
        chk(32'(tx_n), 32'h0);
        wr(6'h07, 32'h00);
        nego;
        repeat (1000) @(posedge clk_sys);
        rdc(6'h02, 32'h20, 32'h20);
        mp_input <= 1'b1;
        wr(6'h03, 32'h70);
        wr(6'h06, 32'h08);
        wait_int;
        rdc(6'h05, 32'h08, 32'h08);
        wr(6'h03, 32'h60);
        nego;
        wr(6'h06, 32'h10);
        wait_int;
        wr(6'h03, 32'h80);
        nego;
        rdc(6'h05, 32'h10, 32'h00);
        wr(6'h01, 32'hff);
        wr(6'h03, 32'h05);
        fork
            u_rem.recv_ext(b);
            wr(6'h07, 32'h5a);
        join
        chk(32'(b), 32'h5a);
        u_rem.send_ext(8'hc3, 1'b1);
        repeat (20) @(posedge clk_sys);
        chk(32'(rx_n), 32'h0);
        wr(6'h06, 32'h02);
        wait_int;
        rdc(6'h07, 32'hff, 32'hc3);
        nego;
        chk(32'(rx_n), 32'h1);
        u_rem.send_ext(8'h00, 1'b0);
        wr(6'h06, 32'h04);
        wait_int;
        wr(6'h03, 32'h50);
        nego;
        wr(6'h03, 32'h10);
        wr(6'h03, 32'h01);
        rdc(6'h01, 32'hff, 32'hff);
        wr(6'h00, 32'h18);
        wr(6'h03, 32'h02);
        wr(6'h00, 32'h00);
        sts(32'h01, 32'h01);
        wr(6'h03, 32'h10);
        sts(32'h01, 32'h00);
        wr(6'h00, 32'h18);
        rdc(6'h00, 32'hff, 32'h18);
        report_and_stop;
    end
endmodule
